// ==== common/cuef_pkg.sv ====
// shared constants for the configuration unlock and error flag block
package cuef_pkg;
    // register byte offsets
    localparam logic [11:0] CUEF_LOCK_KEY_OFF  = 12'h01C;
    localparam logic [11:0] CUEF_ERR_FLAG_OFF  = 12'h020;
    localparam logic [11:0] CUEF_CMD_OFF       = 12'h040;
    localparam logic [11:0] CUEF_TIMING_OFF    = 12'h044;
    // reset values
    localparam logic [31:0] CUEF_ERR_FLAG_RST  = 32'h0000_0000;
    localparam logic [3:0]  CUEF_MAX_SYNC_RST  = 4'hF;
    // unlock key bytes
    localparam logic [7:0]  CUEF_KEY_FIRST     = 8'hCE;
    localparam logic [7:0]  CUEF_KEY_SECOND    = 8'h31;
    // command codes that leave the configuration state
    localparam logic [3:0]  CUEF_CMD_READY     = 4'h2;
    localparam logic [3:0]  CUEF_CMD_MONITOR   = 4'hB;
    localparam logic [3:0]  CUEF_CMD_ASYNC     = 4'hE;
    localparam logic [3:0]  CUEF_CMD_LOOPBACK  = 4'hF;
    // error flag bit positions
    localparam int CUEF_B_MODE_CHG   = 0;
    localparam int CUEF_B_CMD_REJ    = 1;
    localparam int CUEF_B_SYNC_LOW   = 2;
    localparam int CUEF_B_SYNC_OVF   = 3;
    localparam int CUEF_B_CLK_CORR   = 4;
    localparam int CUEF_B_CMD_LOCK   = 5;
    localparam int CUEF_B_PARITY     = 6;
    localparam int CUEF_B_FIFO_OVR   = 7;
    localparam int CUEF_B_EMPTY_FIFO = 8;
    localparam int CUEF_B_ILL_IN     = 9;
    localparam int CUEF_B_ILL_OUT    = 10;
    localparam int CUEF_B_HANDLER    = 11;
    // per channel: channel a at 16, channel b at 24
    localparam int CUEF_B_CHAN_BASE  = 16;
    localparam int CUEF_B_CHAN_STEP  = 8;
    localparam int CUEF_O_CHAN_ERR   = 0;
    localparam int CUEF_O_LATE_TX    = 1;
    localparam int CUEF_O_BOUND_TX   = 2;
    // secure mode field values
    localparam logic [1:0]  CUEF_SEC_STATIC    = 2'h1;
    // unlock sequence states
    typedef enum logic [1:0]
    {
        CUEF_LOCKED,
        CUEF_KEY_ONE,
        CUEF_OPEN
    } cuef_unlock_t;
endpackage : cuef_pkg

// ==== core/cuef_top.sv ====
// configuration unlock sequence, command gate and sticky error flags behind apb
//
// Chosen here: the APB register port.
`timescale 1ns/10ps
// Overview of operation
// - key register is write-only and always reads back as zero
// - leaving configuration needs key writes 0xCE then 0x31 right before
// - any other write after the key breaks unlock; host repeats sequence
// - gate applies to ready, monitor, async transfer and loop-back commands
// - flags set on events, cleared by writing one, zero writes ignored
// - error mode changed flag sets whenever the 2-bit mode value changes
// - command rejected flag sets when an ungated command write is busy or not legal
// - command locked flag sets when previous command busy, with rejected
// - sync low flag: below 1 for sync node, below 2 otherwise
// - sync overflow flag: cycle or double-cycle count above maximum
// - clock correction fail flag set at cycle end on missing or limit
// - parity flag sets on any parity status bit rising
// - fifo overrun event input sets overrun flag
// - empty fifo access flag on fifo transfer request while fifo empty
// - illegal input flag on protected header or fifo transfer request outside configuration
// - illegal input flag on input buffer write while host busy
// - illegal output flag on output transfer request while shadow busy
// - handler constraint flag sets on any of seven constraint bits rising
// - channel error flag sets on any channel status bit rising
// - per channel late transmit and boundary transmission flags
module cuef_top
    import cuef_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        poc_in_config,
    input  wire logic [15:0] cmd_legal,
    input  wire logic        cmd_busy,
    output logic             cmd_strobe,
    output logic      [3:0]  cmd_code,
    input  wire logic [1:0]  error_mode_value,
    input  wire logic        cycle_end,
    input  wire logic        sync_node,
    input  wire logic [3:0]  sync_count_cycle,
    input  wire logic [4:0]  sync_count_double,
    input  wire logic        offset_corr_missing,
    input  wire logic        rate_corr_missing,
    input  wire logic        corr_limit_hit,
    input  wire logic [3:0]  handler_status_parity,
    input  wire logic        fifo_overrun_event,
    input  wire logic        fifo_empty,
    input  wire logic        out_req,
    input  wire logic        out_req_fifo,
    input  wire logic        output_shadow_busy,
    input  wire logic        in_req,
    input  wire logic [7:0]  in_req_index,
    input  wire logic        in_req_header,
    input  wire logic        in_req_key_slot,
    input  wire logic        in_req_fifo,
    input  wire logic [1:0]  secure_mode_field,
    input  wire logic [7:0]  first_dynamic_index,
    input  wire logic        in_reg_write,
    input  wire logic        input_host_busy,
    input  wire logic [6:0]  handler_constraint_flags,
    input  wire logic [7:0]  aggregated_channel_status,
    input  wire logic [1:0]  late_tx_event,
    input  wire logic [1:0]  boundary_tx_event
);

    // address match against one register word
    function automatic logic cuef_hit(input logic [11:0] addr, input logic [11:0] off);
        cuef_hit = (addr[11:2] == off[11:2]);
    endfunction : cuef_hit

    // any bit going from zero to one
    function automatic logic cuef_rise(input logic [7:0] cur, input logic [7:0] prev);
        cuef_rise = |(cur & ~prev);
    endfunction : cuef_rise

    // command codes under the unlock gate
    function automatic logic cuef_leaves_cfg(input logic [3:0] code);
        cuef_leaves_cfg = (code == CUEF_CMD_READY) || (code == CUEF_CMD_MONITOR) ||
                          (code == CUEF_CMD_ASYNC) || (code == CUEF_CMD_LOOPBACK);
    endfunction : cuef_leaves_cfg

    logic [31:0]  prdata_q, prdata_d;
    logic         pready_q, pready_d;
    logic         pslverr_q, pslverr_d;
    logic         cmd_strobe_q, cmd_strobe_d;
    logic [3:0]   cmd_code_q, cmd_code_d;
    logic [3:0]   max_sync_q, max_sync_d;
    cuef_unlock_t unlock_q, unlock_d;
    logic [31:0]  eir_q, eir_d;
    logic [31:0]  eir_set;
    logic [1:0]   mode_prev_q;
    logic [3:0]   parity_prev_q;
    logic [6:0]   handler_prev_q;
    logic [7:0]   acs_prev_q;
    logic         wr_done;
    logic         rd_phase;
    logic         mapped;
    logic         cmd_write;
    logic         cmd_gated;
    logic         cmd_locked_ev;
    logic         cmd_rejected_ev;
    logic         protected_hdr;
    logic [7:0]   sync_min;

    // a transfer finishes on the edge where our registered ready is high
    assign wr_done  = psel && penable && pready_q && pwrite;
    assign rd_phase = psel && penable && !pready_q && !pwrite;
    assign mapped   = cuef_hit(paddr, CUEF_LOCK_KEY_OFF) || cuef_hit(paddr, CUEF_ERR_FLAG_OFF) ||
                      cuef_hit(paddr, CUEF_CMD_OFF) || cuef_hit(paddr, CUEF_TIMING_OFF);

    // apb answer: one wait state, data and error launched with ready
    always_comb
    begin
        pready_d  = psel && penable && !pready_q;
        pslverr_d = psel && penable && !pready_q && !mapped;
        prdata_d  = 32'h0000_0000;
        if (rd_phase)
        begin
            if (cuef_hit(paddr, CUEF_ERR_FLAG_OFF))
                prdata_d = eir_q;
            else if (cuef_hit(paddr, CUEF_CMD_OFF))
                prdata_d = {28'h000_0000, cmd_code_q};
            else if (cuef_hit(paddr, CUEF_TIMING_OFF))
                prdata_d = {28'h000_0000, max_sync_q};
            else
                prdata_d = 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_q  <= 32'h0000_0000;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else
        begin
            prdata_q  <= prdata_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
        end
    end

    // unlock sequence: every completed write either advances or drops it
    always_comb
    begin
        unlock_d = unlock_q;
        if (wr_done)
        begin
            if (cuef_hit(paddr, CUEF_LOCK_KEY_OFF) && pstrb[0] && pwdata[7:0] == CUEF_KEY_FIRST)
                unlock_d = CUEF_KEY_ONE;
            else if (unlock_q == CUEF_KEY_ONE && cuef_hit(paddr, CUEF_LOCK_KEY_OFF) && pstrb[0] &&
                     pwdata[7:0] == CUEF_KEY_SECOND)
                unlock_d = CUEF_OPEN;
            else
                unlock_d = CUEF_LOCKED;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            unlock_q <= CUEF_LOCKED;
        else
            unlock_q <= unlock_d;
    end

    // command gate; a locked-out leave command is dropped, the state stays put
    assign cmd_write       = wr_done && cuef_hit(paddr, CUEF_CMD_OFF) && pstrb[0];
    assign cmd_gated       = cuef_leaves_cfg(pwdata[3:0]) && poc_in_config && (unlock_q != CUEF_OPEN);
    assign cmd_locked_ev   = cmd_write && !cmd_gated && cmd_busy;
    assign cmd_rejected_ev = cmd_write && !cmd_gated && (cmd_busy || !cmd_legal[pwdata[3:0]]);

    always_comb
    begin
        cmd_strobe_d = 1'b0;
        cmd_code_d   = cmd_code_q;
        max_sync_d   = max_sync_q;
        if (cmd_write && !cmd_gated && !cmd_rejected_ev)
        begin
            cmd_strobe_d = 1'b1;
            cmd_code_d   = pwdata[3:0];
        end
        if (wr_done && cuef_hit(paddr, CUEF_TIMING_OFF) && pstrb[0])
            max_sync_d = pwdata[3:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cmd_strobe_q <= 1'b0;
            cmd_code_q   <= 4'h0;
            max_sync_q   <= CUEF_MAX_SYNC_RST;
        end
        else
        begin
            cmd_strobe_q <= cmd_strobe_d;
            cmd_code_q   <= cmd_code_d;
            max_sync_q   <= max_sync_d;
        end
    end

    // protected header decode for input transfer requests
    assign protected_hdr = (in_req_key_slot && in_req_index < 8'h02) ||
                           (in_req_header && secure_mode_field == CUEF_SEC_STATIC &&
                            in_req_index < first_dynamic_index) ||
                           (in_req_header && secure_mode_field[1]) ||
                           in_req_fifo;
    assign sync_min = sync_node ? 8'h01 : 8'h02;

    // set terms for each flag
    always_comb
    begin
        eir_set = 32'h0000_0000;
        eir_set[CUEF_B_MODE_CHG]   = (error_mode_value != mode_prev_q);
        eir_set[CUEF_B_CMD_REJ]    = cmd_rejected_ev;
        eir_set[CUEF_B_CMD_LOCK]   = cmd_locked_ev;
        eir_set[CUEF_B_SYNC_LOW]   = cycle_end && ({4'h0, sync_count_cycle} < sync_min);
        eir_set[CUEF_B_SYNC_OVF]   = cycle_end && ((sync_count_cycle > max_sync_q) ||
                                     (sync_count_double > {1'b0, max_sync_q}));
        eir_set[CUEF_B_CLK_CORR]   = cycle_end && (offset_corr_missing || rate_corr_missing ||
                                     corr_limit_hit);
        eir_set[CUEF_B_PARITY]     = cuef_rise({4'h0, handler_status_parity}, {4'h0, parity_prev_q});
        eir_set[CUEF_B_FIFO_OVR]   = fifo_overrun_event;
        eir_set[CUEF_B_EMPTY_FIFO] = out_req && out_req_fifo && fifo_empty;
        eir_set[CUEF_B_ILL_IN]     = (in_req && !poc_in_config && protected_hdr) ||
                                     (in_reg_write && input_host_busy);
        eir_set[CUEF_B_ILL_OUT]    = out_req && output_shadow_busy;
        eir_set[CUEF_B_HANDLER]    = cuef_rise({1'b0, handler_constraint_flags},
                                               {1'b0, handler_prev_q});
        for (int c = 0; c < 2; c++)
        begin
            eir_set[CUEF_B_CHAN_BASE + c * CUEF_B_CHAN_STEP + CUEF_O_CHAN_ERR] =
                cuef_rise({4'h0, aggregated_channel_status[c*4 +: 4]}, {4'h0, acs_prev_q[c*4 +: 4]});
            eir_set[CUEF_B_CHAN_BASE + c * CUEF_B_CHAN_STEP + CUEF_O_LATE_TX]  = late_tx_event[c];
            eir_set[CUEF_B_CHAN_BASE + c * CUEF_B_CHAN_STEP + CUEF_O_BOUND_TX] = boundary_tx_event[c];
        end
    end

    // write one clears, but a same-cycle set survives
    always_comb
    begin
        eir_d = eir_q;
        if (wr_done && cuef_hit(paddr, CUEF_ERR_FLAG_OFF))
            eir_d = eir_q & ~(pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}});
        eir_d = eir_d | eir_set;
    end

    // history of the levels whose edges raise flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            eir_q          <= CUEF_ERR_FLAG_RST;
            mode_prev_q    <= 2'h0;
            parity_prev_q  <= 4'h0;
            handler_prev_q <= 7'h00;
            acs_prev_q     <= 8'h00;
        end
        else
        begin
            eir_q          <= eir_d;
            mode_prev_q    <= error_mode_value;
            parity_prev_q  <= handler_status_parity;
            handler_prev_q <= handler_constraint_flags;
            acs_prev_q     <= aggregated_channel_status;
        end
    end

    assign prdata     = prdata_q;
    assign pready     = pready_q;
    assign pslverr    = pslverr_q;
    assign cmd_strobe = cmd_strobe_q;
    assign cmd_code   = cmd_code_q;

    a_key_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready_q && !pwrite && cuef_hit(paddr, CUEF_LOCK_KEY_OFF)) |-> (prdata_q == 32'h0000_0000))
        else $error("key register read not zero");

    a_gate_blocks_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_write && poc_in_config && cuef_leaves_cfg(pwdata[3:0]) && unlock_q != CUEF_OPEN) |=> !cmd_strobe_q)
        else $error("leave command issued without unlock");

    a_open_issues_cmd: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_write && unlock_q == CUEF_OPEN && !cmd_busy && cmd_legal[pwdata[3:0]])
        |=> (cmd_strobe_q && cmd_code_q == $past(pwdata[3:0])))
        else $error("unlocked command not issued");

    a_locked_sets_both: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_write && !cmd_gated && cmd_busy) |=> (eir_q[CUEF_B_CMD_LOCK] && eir_q[CUEF_B_CMD_REJ] && !cmd_strobe_q))
        else $error("locked command flags missing");

    a_mode_change_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (error_mode_value != mode_prev_q) |=> eir_q[CUEF_B_MODE_CHG])
        else $error("mode change not flagged");

    a_sync_low_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && !sync_node && sync_count_cycle == 4'h1) |=> eir_q[CUEF_B_SYNC_LOW])
        else $error("sync low not flagged for one frame");

    a_flag_holds: assert property (@(posedge pclk) disable iff (!presetn)
        (eir_q[CUEF_B_FIFO_OVR] && !(wr_done && cuef_hit(paddr, CUEF_ERR_FLAG_OFF) && pwdata[CUEF_B_FIFO_OVR]))
        |=> eir_q[CUEF_B_FIFO_OVR])
        else $error("overrun flag dropped without clear");

    a_set_beats_clear: assert property (@(posedge pclk) disable iff (!presetn)
        (fifo_overrun_event && wr_done && cuef_hit(paddr, CUEF_ERR_FLAG_OFF) && pwdata[CUEF_B_FIFO_OVR])
        |=> eir_q[CUEF_B_FIFO_OVR])
        else $error("set lost against clear");

    a_ready_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !pready_q) |=> pready_q ##1 !pready_q)
        else $error("apb ready timing wrong");

    // flag set terms and gate outcomes, one cycle after their cause
    a_cmd_rej_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (cmd_write && !cmd_gated && !cmd_busy && !cmd_legal[pwdata[3:0]]) |=> (eir_q[CUEF_B_CMD_REJ] && !cmd_strobe_q))
        else $error("rejected command not flagged");

    a_sync_ovf_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && sync_count_double > {1'b0, max_sync_q}) |=> eir_q[CUEF_B_SYNC_OVF])
        else $error("sync overflow not flagged");

    a_clk_corr_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (cycle_end && (offset_corr_missing || rate_corr_missing || corr_limit_hit)) |=> eir_q[CUEF_B_CLK_CORR])
        else $error("correction failure not flagged");

    a_parity_rise_flag: assert property (@(posedge pclk) disable iff (!presetn)
        ((handler_status_parity & ~parity_prev_q) != 4'h0) |=> eir_q[CUEF_B_PARITY])
        else $error("parity rise not flagged");

    a_fifo_ovr_flag: assert property (@(posedge pclk) disable iff (!presetn)
        fifo_overrun_event |=> eir_q[CUEF_B_FIFO_OVR])
        else $error("overrun not flagged");

    a_empty_fifo_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (out_req && out_req_fifo && fifo_empty) |=> eir_q[CUEF_B_EMPTY_FIFO])
        else $error("empty fifo access not flagged");

    a_ill_out_flag: assert property (@(posedge pclk) disable iff (!presetn)
        (out_req && output_shadow_busy) |=> eir_q[CUEF_B_ILL_OUT])
        else $error("illegal output access not flagged");

    a_late_tx_flag: assert property (@(posedge pclk) disable iff (!presetn)
        late_tx_event[1] |=> eir_q[CUEF_B_CHAN_BASE + CUEF_B_CHAN_STEP + CUEF_O_LATE_TX])
        else $error("late transmit not flagged");

    a_clear_by_one: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && cuef_hit(paddr, CUEF_ERR_FLAG_OFF) && pstrb[1] && pwdata[CUEF_B_EMPTY_FIFO] &&
         !eir_set[CUEF_B_EMPTY_FIFO]) |=> !eir_q[CUEF_B_EMPTY_FIFO])
        else $error("flag not cleared by one");

    a_other_write_locks: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_done && !cuef_hit(paddr, CUEF_LOCK_KEY_OFF)) |=> (unlock_q == CUEF_LOCKED))
        else $error("unlock survived another write");

    a_strobe_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        cmd_strobe_q |=> !cmd_strobe_q)
        else $error("command strobe longer than one cycle");

endmodule : cuef_top

// ==== sim/test_config_unlock_and_error_flags.sv ====
// self-checking testbench for the unlock sequence, command gate and sticky error flags
`timescale 1ns/10ps
module test_config_unlock_and_error_flags;
    import cuef_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat, e;
    logic [3:0]  pstrb = 4'hF, cmd_code, sync_count_cycle, handler_status_parity, sb;
    logic        poc_in_config = 1'b1, cmd_busy = 1'b0, cmd_strobe, pready, pslverr, rerr;
    logic        cycle_end, sync_node, offset_corr_missing, rate_corr_missing, corr_limit_hit;
    logic        fifo_overrun_event, fifo_empty, out_req, out_req_fifo, output_shadow_busy;
    logic        in_req, in_req_header, in_req_key_slot, in_req_fifo, in_reg_write, input_host_busy;
    logic [15:0] cmd_legal = 16'hFFFF;
    logic [1:0]  error_mode_value = 2'h0, secure_mode_field, late_tx_event, boundary_tx_event;
    logic [4:0]  sync_count_double;
    logic [7:0]  in_req_index, first_dynamic_index = 8'h08, aggregated_channel_status;
    logic [6:0]  handler_constraint_flags;
    int          n_mismatch = 0, n_compared = 0, n_strobe = 0, n_cycles = 0;
    localparam int CA = CUEF_B_CHAN_BASE;
    localparam int CB = CUEF_B_CHAN_BASE + CUEF_B_CHAN_STEP;
    // flag bit hit by each event case; cases 23 and up must set nothing
    localparam int FLAG_POS [0:22] = '{CUEF_B_MODE_CHG, CUEF_B_SYNC_LOW, CUEF_B_SYNC_OVF, CUEF_B_SYNC_OVF,
        CUEF_B_CLK_CORR, CUEF_B_CLK_CORR, CUEF_B_CLK_CORR, CUEF_B_PARITY, CUEF_B_FIFO_OVR, CUEF_B_EMPTY_FIFO,
        CUEF_B_ILL_OUT, CUEF_B_ILL_IN, CUEF_B_ILL_IN, CUEF_B_ILL_IN, CUEF_B_ILL_IN, CUEF_B_ILL_IN, CUEF_B_HANDLER,
        CA + CUEF_O_CHAN_ERR, CB + CUEF_O_CHAN_ERR, CA + CUEF_O_LATE_TX, CB + CUEF_O_LATE_TX,
        CA + CUEF_O_BOUND_TX, CB + CUEF_O_BOUND_TX};
    localparam logic [3:0] GATED [0:3] = '{CUEF_CMD_READY, CUEF_CMD_MONITOR, CUEF_CMD_ASYNC, CUEF_CMD_LOOPBACK};

    cuef_top uut
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .poc_in_config, .cmd_legal, .cmd_busy, .cmd_strobe, .cmd_code, .error_mode_value, .cycle_end,
        .sync_node, .sync_count_cycle, .sync_count_double, .offset_corr_missing, .rate_corr_missing,
        .corr_limit_hit, .handler_status_parity, .fifo_overrun_event, .fifo_empty, .out_req, .out_req_fifo,
        .output_shadow_busy, .in_req, .in_req_index, .in_req_header, .in_req_key_slot, .in_req_fifo,
        .secure_mode_field, .first_dynamic_index, .in_reg_write, .input_host_busy, .handler_constraint_flags,
        .aggregated_channel_status, .late_tx_event, .boundary_tx_event
    );

    // 200 MHz clock
    initial
    begin
        forever #2.5 pclk = ~pclk;
    end

    // accepted commands and the hang limit; 5000 cycles is well above the planned run
    always @(posedge pclk)
    begin
        n_cycles++;
        if (cmd_strobe === 1'b1)
            n_strobe++;
        if (n_cycles == 5000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    // one apb transfer; request held until pready is seen, data taken for that same edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        pstrb   <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st = 4'hF);
        apb(1'b1, a, wd, st);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        apb(1'b0, a, 32'h0, 4'hF);
    endtask : rd

    task automatic unlock();
        wr(CUEF_LOCK_KEY_OFF, {24'h0, CUEF_KEY_FIRST});
        wr(CUEF_LOCK_KEY_OFF, {24'h0, CUEF_KEY_SECOND});
    endtask : unlock

    // quiet levels for every event input; the error mode is left where it stands
    task automatic set_idle();
        {cycle_end, sync_node, offset_corr_missing, rate_corr_missing, corr_limit_hit} <= 5'h00;
        {fifo_overrun_event, out_req, out_req_fifo, output_shadow_busy, in_req_fifo} <= 5'h00;
        {in_req, in_req_header, in_req_key_slot, in_reg_write, input_host_busy} <= 5'h00;
        {late_tx_event, boundary_tx_event, handler_status_parity} <= 8'h00;
        {aggregated_channel_status, handler_constraint_flags} <= 15'h0000;
        {sync_count_cycle, sync_count_double, secure_mode_field} <= {4'h3, 5'h03, 2'h0};
        in_req_index <= 8'h01;
        fifo_empty   <= 1'b1;
    endtask : set_idle

    // one cycle of stimulus for event case k
    task automatic apply_event(input int k);
        @(posedge pclk);
        cycle_end        <= k inside {[1:6], 23};
        sync_node        <= (k == 23);
        sync_count_cycle <= (k inside {1, 23}) ? 4'h1 : ((k == 2) ? 4'h5 : 4'h3);
        in_req           <= k inside {[11:14], 24, 25, 26};
        in_req_key_slot  <= k inside {11, 24, 26};
        in_req_header    <= k inside {12, 13, 25};
        in_req_index     <= (k == 24) ? 8'h02 : ((k == 25) ? 8'h08 : 8'h01);
        secure_mode_field <= (k == 13) ? 2'h2 : CUEF_SEC_STATIC;
        out_req          <= k inside {9, 10};
        in_reg_write     <= (k == 15);
        poc_in_config    <= (k == 26);
        case (k)
            0: error_mode_value <= 2'h1;
            3: sync_count_double <= 5'h05;
            4: offset_corr_missing <= 1'b1;
            5: rate_corr_missing <= 1'b1;
            6: corr_limit_hit <= 1'b1;
            7: handler_status_parity <= 4'h4;
            8: fifo_overrun_event <= 1'b1;
            9: out_req_fifo <= 1'b1;
            10: output_shadow_busy <= 1'b1;
            14: in_req_fifo <= 1'b1;
            15: input_host_busy <= 1'b1;
            16: handler_constraint_flags <= 7'h40;
            17: aggregated_channel_status <= 8'h02;
            18: aggregated_channel_status <= 8'h20;
            19: late_tx_event <= 2'h1;
            20: late_tx_event <= 2'h2;
            21: boundary_tx_event <= 2'h1;
            22: boundary_tx_event <= 2'h2;
            default: ;
        endcase
        @(posedge pclk);
        set_idle();
        poc_in_config <= 1'b0;
    endtask : apply_event

    // main sequence
    initial
    begin
        set_idle();
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd(CUEF_ERR_FLAG_OFF);
        check(rdat, CUEF_ERR_FLAG_RST);
        rd(12'h100);
        check({rdat[30:0], rerr}, 32'h0000_0001);
        // gated command without the key is dropped
        wr(CUEF_CMD_OFF, {28'h0, CUEF_CMD_READY});
        rd(CUEF_CMD_OFF);
        check(rdat, 32'h0);
        foreach (GATED[i])
        begin
            unlock();
            wr(CUEF_CMD_OFF, {28'h0, GATED[i]});
            rd(CUEF_CMD_OFF);
            check(rdat, {28'h0, GATED[i]});
        end
        // a read between key and command is not a write, so the command still passes
        unlock();
        rd(CUEF_LOCK_KEY_OFF);
        check(rdat, 32'h0000_0000);
        wr(CUEF_CMD_OFF, {28'h0, CUEF_CMD_READY});
        unlock();
        wr(CUEF_TIMING_OFF, 32'h4);
        wr(CUEF_CMD_OFF, {28'h0, CUEF_CMD_LOOPBACK});
        rd(CUEF_CMD_OFF);
        check(rdat, {28'h0, CUEF_CMD_READY});
        cmd_busy <= 1'b1;
        wr(CUEF_CMD_OFF, 32'h3);
        rd(CUEF_ERR_FLAG_OFF);
        check(rdat, (32'h1 << CUEF_B_CMD_LOCK) | (32'h1 << CUEF_B_CMD_REJ));
        wr(CUEF_ERR_FLAG_OFF, 32'hFFFF_FFFF);
        cmd_busy  <= 1'b0;
        cmd_legal <= 16'hFFF7;
        wr(CUEF_CMD_OFF, 32'h3);
        rd(CUEF_ERR_FLAG_OFF);
        check(rdat, 32'h1 << CUEF_B_CMD_REJ);
        wr(CUEF_ERR_FLAG_OFF, 32'hFFFF_FFFF);
        cmd_legal <= 16'hFFFF;
        wr(CUEF_CMD_OFF, 32'h3);
        rd(CUEF_TIMING_OFF);
        check(rdat, 32'h0000_0004);
        check({28'h0, cmd_code}, 32'h3);
        check(n_strobe, 32'h6);
        // each event: flag set, kept through other lanes and zero writes, cleared by a one
        for (int k = 0; k < 27; k++)
        begin
            apply_event(k);
            e = (k < 23) ? (32'h1 << FLAG_POS[k]) : 32'h0;
            sb = {|e[31:24], |e[23:16], |e[15:8], |e[7:0]};
            rd(CUEF_ERR_FLAG_OFF);
            check(rdat, e);
            wr(CUEF_ERR_FLAG_OFF, 32'hFFFF_FFFF, ~sb);
            wr(CUEF_ERR_FLAG_OFF, ~e);
            rd(CUEF_ERR_FLAG_OFF);
            check(rdat, e);
            wr(CUEF_ERR_FLAG_OFF, e);
            rd(CUEF_ERR_FLAG_OFF);
            check(rdat, 32'h0);
        end
        // overrun in the very cycle its clear lands: the set must win
        fork
            wr(CUEF_ERR_FLAG_OFF, 32'h1 << CUEF_B_FIFO_OVR);
            begin
                repeat (3) @(posedge pclk);
                fifo_overrun_event <= 1'b1;
                @(posedge pclk);
                fifo_overrun_event <= 1'b0;
            end
        join
        rd(CUEF_ERR_FLAG_OFF);
        check(rdat, 32'h1 << CUEF_B_FIFO_OVR);
        give_verdict();
    end
endmodule : test_config_unlock_and_error_flags
